// *** design/lpa_pkg.sv ***
// Package for the link partner ability register block.
// Assumes one management/core clock domain and a 5-bit register address.
package lpa_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [4:0] LPA_ADDR = 5'h05;
    localparam logic [15:0] LPA_RESET = 16'h0000;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int LPA_NP_BIT = 15;
    localparam int LPA_ACK_BIT = 14;
    localparam int LPA_RF_BIT = 13;
    localparam int LPA_T4_BIT = 9;
    localparam int LPA_TAF_LSB = 5;
    localparam int LPA_SEL_LSB = 0;
    localparam logic [15:0] LPA_RSVD_MASK = 16'h1E00;

    // ------------------------------------------------------------------
    // Selector codes
    // ------------------------------------------------------------------
    localparam logic [4:0] LPA_SEL_ETH = 5'h01;
    localparam logic [4:0] LPA_SEL_ISLAN = 5'h02;

    // Decoded selector class
    typedef enum logic [1:0] {
        LPA_SEL_INVALID = 2'b00,
        LPA_SEL_IS_ETH = 2'b01,
        LPA_SEL_IS_ISLAN = 2'b10
    } lpa_sel_t;

    // Management access request
    typedef struct packed {
        logic rd;
        logic wr;
        logic [4:0] addr;
        logic [15:0] wdata;
    } lpa_mgmt_req_t;

    // Received page from the negotiation engine
    typedef struct packed {
        logic valid;
        logic [15:0] word;
    } lpa_page_t;

endpackage : lpa_pkg

// *** design/lpa_reg.sv ***
// Link partner ability register with management access.
// Assumes page strobe and management requests are on clk_i.
// Contract
// - Every bit except 12..9 is loaded from the partner's received link code word.
// - Bit 15 mirrors the partner next-page flag.
// - Bit 14 reports the partner acknowledge flag.
// - Bit 13 reports the partner remote-fault flag.
// - Bits 8..5 hold the 100FD, 100HD, 10FD, 10HD abilities in order.
// - Bit 9 (four-pair ability) always reads zero.
// - Reserved bits 12..10 always read zero.
// - Bits 4..0 hold the selector; only the Ethernet code is supported.
// - Selector decode knows exactly two codes, 00001b and 00010b.
// - Override-writable bits take writes only while override is set.
`timescale 1ns/1ps
module lpa_reg
    import lpa_pkg::*;
(
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // Negotiation engine side
    input wire lpa_page_t page_i,
    input wire logic an_complete_i,
    input wire logic override_i,
    // Management side
    input wire lpa_mgmt_req_t mgmt_i,
    output logic [15:0] rdata_o,
    // Status
    output logic valid_o,
    output logic sel_supported_o,
    output lpa_sel_t sel_class_o
);

    // ------------------------------------------------------------------
    // Selector decode
    // ------------------------------------------------------------------
    function automatic lpa_sel_t sel_decode(input logic [4:0] sel);
        unique case (sel)
            LPA_SEL_ETH: sel_decode = LPA_SEL_IS_ETH;
            LPA_SEL_ISLAN: sel_decode = LPA_SEL_IS_ISLAN;
            default: sel_decode = LPA_SEL_INVALID;
        endcase
    endfunction : sel_decode

    // ------------------------------------------------------------------
    // Internal state
    // ------------------------------------------------------------------
    // Stored partner word, its next value and the read-data flop
    logic [15:0] lpa_r;
    logic [15:0] lpa_nxt;
    logic [15:0] rdata_r;
    logic wr_hit;

    // A write counts only when it addresses this register
    assign wr_hit = mgmt_i.wr && (mgmt_i.addr == LPA_ADDR);

    // ------------------------------------------------------------------
    // Next value: page load wins over management write
    // ------------------------------------------------------------------
    always_comb
    begin
        lpa_nxt = lpa_r;
        if (page_i.valid)
        begin
            lpa_nxt = page_i.word;
        end
        else if (wr_hit && override_i)
        begin
            lpa_nxt = mgmt_i.wdata;
        end
        // Cleared last so neither path can ever store bits 12..9
        lpa_nxt = lpa_nxt & ~LPA_RSVD_MASK;
    end

    // ------------------------------------------------------------------
    // Storage and read path
    // ------------------------------------------------------------------
    // Register storage, holds between pages and override writes; a low enable freezes it
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            lpa_r <= LPA_RESET;
        else if (ce_i)
            lpa_r <= lpa_nxt;
    end

    // Registered read data
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            rdata_r <= LPA_RESET;
        else if (ce_i && mgmt_i.rd)
            rdata_r <= (mgmt_i.addr == LPA_ADDR) ? lpa_r : 16'h0000;
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Status decodes follow the stored word without extra delay
    assign rdata_o = rdata_r;
    assign valid_o = an_complete_i; // Qualifier for software
    assign sel_class_o = sel_decode(lpa_r[LPA_SEL_LSB +: 5]);
    assign sel_supported_o = (lpa_r[LPA_SEL_LSB +: 5] == LPA_SEL_ETH);

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    property p_page_load;
        @(posedge clk_i) disable iff (!rst_n_i)
        (ce_i && page_i.valid) |=>
            lpa_r == ($past(page_i.word) & ~LPA_RSVD_MASK);
    endproperty
    a_page_load: assert property (p_page_load)
        else $error("page not loaded");

    property p_np;
        @(posedge clk_i) disable iff (!rst_n_i)
        (ce_i && page_i.valid) |=>
            lpa_r[LPA_NP_BIT] == $past(page_i.word[LPA_NP_BIT]);
    endproperty
    a_np: assert property (p_np)
        else $error("next page flag wrong");

    property p_ack;
        @(posedge clk_i) disable iff (!rst_n_i)
        (ce_i && page_i.valid) |=>
            lpa_r[LPA_ACK_BIT] == $past(page_i.word[LPA_ACK_BIT]);
    endproperty
    a_ack: assert property (p_ack)
        else $error("ack flag wrong");

    property p_rf;
        @(posedge clk_i) disable iff (!rst_n_i)
        (ce_i && page_i.valid) |=>
            lpa_r[LPA_RF_BIT] == $past(page_i.word[LPA_RF_BIT]);
    endproperty
    a_rf: assert property (p_rf)
        else $error("remote fault wrong");

    property p_taf;
        @(posedge clk_i) disable iff (!rst_n_i)
        (ce_i && page_i.valid) |=>
            lpa_r[LPA_TAF_LSB +: 4] == $past(page_i.word[LPA_TAF_LSB +: 4]);
    endproperty
    a_taf: assert property (p_taf)
        else $error("ability bits wrong");

    property p_t4;
        @(posedge clk_i) disable iff (!rst_n_i)
        ##1 lpa_r[LPA_T4_BIT] == 1'b0;
    endproperty
    a_t4: assert property (p_t4)
        else $error("four-pair bit set");

    property p_rsvd;
        @(posedge clk_i) disable iff (!rst_n_i)
        (ce_i && mgmt_i.rd) |=> rdata_o[12:10] == 3'h0;
    endproperty
    a_rsvd: assert property (p_rsvd)
        else $error("reserved bits nonzero");

    property p_sel;
        @(posedge clk_i) disable iff (!rst_n_i)
        sel_supported_o == (sel_class_o == LPA_SEL_IS_ETH);
    endproperty
    a_sel: assert property (p_sel)
        else $error("selector support wrong");

    property p_isl;
        @(posedge clk_i) disable iff (!rst_n_i)
        (lpa_r[4:0] == LPA_SEL_ISLAN) |-> sel_class_o == LPA_SEL_IS_ISLAN;
    endproperty
    a_isl: assert property (p_isl)
        else $error("second selector code missed");

    property p_ovr;
        @(posedge clk_i) disable iff (!rst_n_i)
        (ce_i && wr_hit && !override_i && !page_i.valid) |=> $stable(lpa_r);
    endproperty
    a_ovr: assert property (p_ovr)
        else $error("write taken without override");

    property p_hold;
        @(posedge clk_i) disable iff (!rst_n_i)
        (!page_i.valid && !wr_hit) |=> $stable(lpa_r);
    endproperty
    a_hold: assert property (p_hold)
        else $error("register changed without page");

    property p_ovr_take;
        @(posedge clk_i) disable iff (!rst_n_i)
        (ce_i && wr_hit && override_i && !page_i.valid) |=>
            lpa_r == ($past(mgmt_i.wdata) & ~LPA_RSVD_MASK);
    endproperty
    a_ovr_take: assert property (p_ovr_take)
        else $error("override write not taken");

    property p_rd_hit;
        @(posedge clk_i) disable iff (!rst_n_i)
        (ce_i && mgmt_i.rd && mgmt_i.addr == LPA_ADDR) |=>
            rdata_o == $past(lpa_r);
    endproperty
    a_rd_hit: assert property (p_rd_hit)
        else $error("read data differs from register");

    property p_freeze;
        @(posedge clk_i) disable iff (!rst_n_i)
        !ce_i |=> $stable(lpa_r) && $stable(rdata_o);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("state moved with enable low");

    // ------------------------------------------------------------------
    // Cover points
    // ------------------------------------------------------------------
    c_page: cover property (@(posedge clk_i) ce_i && page_i.valid);
    c_ovr_wr: cover property (@(posedge clk_i) ce_i && wr_hit && override_i);
    c_rd: cover property (@(posedge clk_i) ce_i && mgmt_i.rd && valid_o);
    c_clash: cover property (@(posedge clk_i) ce_i && page_i.valid && wr_hit);
    c_frozen: cover property (@(posedge clk_i) !ce_i && page_i.valid);

endmodule : lpa_reg

// *** test/lpa_far_end.sv ***
// Far-end page source that hands received link code words to the register.
// Assumes the bench calls send at a falling clock edge.
`timescale 1ns/1ps
module lpa_far_end
    import lpa_pkg::*;
(
    // Clock
    input wire logic clk_i,
    // Page toward the register
    output lpa_page_t page_o
);
    initial page_o = '{1'b0, 16'h0000};
    // One-cycle strobe; the released word is inverted, not held
    task automatic send(input logic [15:0] w);
        page_o = '{1'b1, w};
        @(negedge clk_i);
        page_o = '{1'b0, ~w};
    endtask : send
endmodule : lpa_far_end

// *** test/test_lpa_reg.sv ***
// Self-checking bench for the partner ability register.
// Assumes lpa_pkg and lpa_far_end are compiled first.
`timescale 1ns/1ps
module test_lpa_reg;
    import lpa_pkg::*;
    logic clk_i = 0, rst_n_i = 0, ce_i = 1, an_complete_i = 0;
    logic override_i = 0, rd_q = 0, valid_o, sel_supported_o;
    lpa_page_t page_i;
    lpa_mgmt_req_t mgmt_i = '0;
    lpa_sel_t sel_class_o;
    logic [15:0] rdata_o, w, reg_m, exp_q[$];
    logic [31:0] seed = 32'h2E8EC276;
    int error_cnt = 0, cmp_count = 0;
    lpa_reg u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
        .page_i(page_i), .an_complete_i(an_complete_i),
        .override_i(override_i), .mgmt_i(mgmt_i), .rdata_o(rdata_o),
        .valid_o(valid_o), .sel_supported_o(sel_supported_o),
        .sel_class_o(sel_class_o));
    lpa_far_end u_far (.clk_i(clk_i), .page_o(page_i));
    function automatic logic [15:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[15:0];
    endfunction : rnd
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR %0t: saw %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic op(input logic rd, input logic wr, input logic [4:0] a,
        input logic [15:0] d);
        // Reserved bits 12..10 always go out as zero
        mgmt_i = '{rd, wr, a, d & 16'hE3FF};
        an_complete_i = seed[3];
        @(negedge clk_i);
        mgmt_i.rd = 1'b0;
        mgmt_i.wr = 1'b0;
        // Idle edge so the next strobe never rises where this one fell
        @(negedge clk_i);
    endtask : op
    task automatic rd_exp(input logic [4:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        op(1'b1, 1'b0, a, rnd());
    endtask : rd_exp
    task automatic report_and_stop();
        $display("Compares %0d, errors %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : report_and_stop
    initial forever #5 clk_i = ~clk_i;
    always @(posedge clk_i) rd_q <= mgmt_i.rd & ce_i;
    // Each read result is matched against the oldest note
    always @(negedge clk_i)
        if (rd_q) check(rdata_o, exp_q.pop_front());
    initial
    begin
        #50us;
        error_cnt++;
        report_and_stop();
    end
    initial
    begin
        repeat (4) @(negedge clk_i);
        rst_n_i = 1'b1;
        rd_exp(LPA_ADDR, LPA_RESET);
        // Pages with every selector class, and reserved bits set on odd ones
        for (int i = 0; i < 8; i++)
        begin
            w = rnd();
            w[4:0] = {3'h0, i[1:0]};
            if (i[0]) w[12:9] = 4'hF;
            u_far.send(w);
            reg_m = w & ~LPA_RSVD_MASK;
            check({15'h0000, sel_supported_o},
                {15'h0000, i[1:0] == 2'h1});
            check({14'h0000, sel_class_o},
                {14'h0000, ((i[1:0] == 2'h3) ? 2'h0 : i[1:0])});
            check({15'h0000, valid_o}, {15'h0000, an_complete_i});
            rd_exp(LPA_ADDR, reg_m);
            // Read data has bits 12..9 clear
            check(rdata_o & LPA_RSVD_MASK, 16'h0000);
        end
        // Writes refused without override, taken masked with it
        w = rnd();
        op(1'b0, 1'b1, LPA_ADDR, w);
        rd_exp(LPA_ADDR, reg_m);
        override_i = 1'b1;
        op(1'b0, 1'b1, LPA_ADDR, w | 16'h1E00);
        rd_exp(LPA_ADDR, w & ~LPA_RSVD_MASK);
        op(1'b0, 1'b1, 5'h06, rnd());
        rd_exp(5'h06, 16'h0000);
        rd_exp(LPA_ADDR, w & ~LPA_RSVD_MASK);
        // Page beats a write in the same cycle
        reg_m = rnd();
        fork
            u_far.send(reg_m);
            op(1'b0, 1'b1, LPA_ADDR, ~reg_m);
        join
        rd_exp(LPA_ADDR, reg_m & ~LPA_RSVD_MASK);
        // Clock enable low freezes the register
        ce_i = 1'b0;
        u_far.send(~reg_m);
        ce_i = 1'b1;
        rd_exp(LPA_ADDR, reg_m & ~LPA_RSVD_MASK);
        // Reset in mid-run clears the register and the read data
        rst_n_i = 1'b0;
        @(negedge clk_i);
        check(rdata_o, LPA_RESET);
        rst_n_i = 1'b1;
        rd_exp(LPA_ADDR, LPA_RESET);
        repeat (2) @(negedge clk_i);
        report_and_stop();
    end
endmodule : test_lpa_reg
